// file: iocd_defs.svh
// Constants for the I/O bus command decoder: field positions, codes, reset values
`ifndef IOCD_DEFS_SVH
`define IOCD_DEFS_SVH
`define IOCD_BUS_W        24
`define IOCD_BASIC_HI     23
`define IOCD_BASIC_LO     20
`define IOCD_CHAN_HI      19
`define IOCD_CHAN_LO      16
`define IOCD_DATA_HI      15
`define IOCD_SUB_HI       3
`define IOCD_STAT_HI      20
`define IOCD_STAT_LO      16
`define IOCD_REVERSE_BIT  21
`define IOCD_ID_HI        6
`define IOCD_ID_LO        1
`define IOCD_CODE_SUB     4'h1
`define IOCD_CODE_XOUTA   4'h2
`define IOCD_CODE_XOUTB   4'h3
`define IOCD_CODE_XIN     4'h4
`define IOCD_SUB_TSTAT    4'h1
`define IOCD_SUB_CLRTST   4'h3
`define IOCD_SUB_TSRQ     4'h5
`define IOCD_SUB_TERM     4'h6
`define IOCD_BUS_ZERO     24'h000000
`define IOCD_DATA_ZERO    16'h0000
`endif

// file: iocd_pkg.sv
// Types for the I/O bus command decoder
`default_nettype none
package iocd_pkg;
  // Decoded command kinds held between the two phases
  typedef enum logic [2:0] {
    IOCD_CMD_NONE   = 3'b000,
    IOCD_CMD_XOUTA  = 3'b001,
    IOCD_CMD_XIN    = 3'b010,
    IOCD_CMD_TSTAT  = 3'b011,
    IOCD_CMD_CLRTST = 3'b100,
    IOCD_CMD_TSRQ   = 3'b101,
    IOCD_CMD_TERM   = 3'b110
  } iocd_cmd_type;
  // Drive value and lane enables of the shared bus pins
  typedef struct packed {
    logic [23:0] dout;
    logic [23:0] oe;
  } iocd_drive_type;
endpackage
`default_nettype wire

// file: iocd_decoder.sv
// I/O bus command decoder inside one I/O control
`timescale 1ns/1ps
`default_nettype none
`include "iocd_defs.svh"
module iocd_decoder
  import iocd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        command_active_strobe,
  input  wire logic        response_complete_strobe,
  input  wire logic [23:0] bus_in,
  output var  logic [23:0] bus_out,
  output var  logic [23:0] bus_oe,
  output var  logic        bus_send_direction,
  input  wire logic [3:0]  own_channel,
  input  wire logic [5:0]  control_id,
  input  wire logic [4:0]  status_count,
  input  wire logic [15:0] input_data,
  input  wire logic        service_request,
  output var  logic [15:0] out_data,
  output var  logic        out_data_valid,
  output var  logic        clear_pulse,
  output var  logic        terminate_pulse
);

  // ****************************************
  // Command decode
  // ****************************************
  // Sub-command decoding shared by several terms
  function automatic iocd_cmd_type iocd_sub_decode(input logic [3:0] sub);
    case (sub)
      `IOCD_SUB_TSTAT:  iocd_sub_decode = IOCD_CMD_TSTAT;
      `IOCD_SUB_CLRTST: iocd_sub_decode = IOCD_CMD_CLRTST;
      `IOCD_SUB_TSRQ:   iocd_sub_decode = IOCD_CMD_TSRQ;
      `IOCD_SUB_TERM:   iocd_sub_decode = IOCD_CMD_TERM;
      default:          iocd_sub_decode = IOCD_CMD_NONE;
    endcase
  endfunction

  wire logic [3:0]   basic_code;  // Top four bits
  wire logic [3:0]   chan_field;  // Channel field
  wire logic         chan_match;  // Addressed to this control
  iocd_cmd_type      decoded;     // Decoded command of the word on the bus

  assign basic_code = bus_in[`IOCD_BASIC_HI:`IOCD_BASIC_LO];
  assign chan_field = bus_in[`IOCD_CHAN_HI:`IOCD_CHAN_LO];
  assign chan_match = (chan_field == own_channel);

  // Decode; service test ignores channel, reserved code yields none
  always_comb begin
    case (basic_code)
      `IOCD_CODE_XOUTA: decoded = chan_match ? IOCD_CMD_XOUTA : IOCD_CMD_NONE;
      `IOCD_CODE_XIN:   decoded = chan_match ? IOCD_CMD_XIN : IOCD_CMD_NONE;
      `IOCD_CODE_SUB: begin
        if (iocd_sub_decode(bus_in[`IOCD_SUB_HI:0]) == IOCD_CMD_TSRQ) begin
          decoded = IOCD_CMD_TSRQ;
        end else begin
          decoded = chan_match ? iocd_sub_decode(bus_in[`IOCD_SUB_HI:0]) : IOCD_CMD_NONE;
        end
      end
      default:          decoded = IOCD_CMD_NONE;
    endcase
  end

  // ****************************************
  // Phase tracking
  // ****************************************
  typedef enum logic [1:0] {
    IOCD_IDLE  = 2'b00,
    IOCD_WAITB = 2'b01
  } iocd_state_type;

  iocd_state_type state_ff;   // Between phases or idle
  iocd_state_type nxt_state;  // Next phase state
  iocd_cmd_type   cmd_ff;     // Command held for phase B
  wire logic      strobe_a;   // Phase A strobe
  wire logic      strobe_b;   // Phase B strobe in progress

  assign strobe_a = command_active_strobe;
  assign strobe_b = response_complete_strobe && (state_ff == IOCD_WAITB);

  // Phase A moves to waiting, phase B returns idle
  always_comb begin
    case (state_ff)
      IOCD_IDLE:  nxt_state = strobe_a ? IOCD_WAITB : IOCD_IDLE;
      IOCD_WAITB: nxt_state = response_complete_strobe ? IOCD_IDLE : IOCD_WAITB;
      default:    nxt_state = IOCD_IDLE;
    endcase
  end

  // Phase register and captured command
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= IOCD_IDLE;
      cmd_ff   <= IOCD_CMD_NONE;
    end else begin
      state_ff <= nxt_state;
      if (strobe_a) begin
        cmd_ff <= decoded;
      end else if (strobe_b) begin
        cmd_ff <= IOCD_CMD_NONE;
      end
    end
  end

  // ****************************************
  // Phase A actions
  // ****************************************
  // Data latch for transfer out
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_data        <= `IOCD_DATA_ZERO;
      out_data_valid  <= 1'b0;
      terminate_pulse <= 1'b0;
    end else begin
      out_data_valid  <= strobe_a && (decoded == IOCD_CMD_XOUTA);
      terminate_pulse <= strobe_a && (decoded == IOCD_CMD_TERM);
      if (strobe_a && (decoded == IOCD_CMD_XOUTA)) begin
        out_data <= bus_in[`IOCD_DATA_HI:0];
      end
    end
  end

  // ****************************************
  // Phase B answer
  // ****************************************
  wire logic [23:0] stat_word; // Status count with reverse bit
  wire logic [23:0] ans_word;  // Answer for held command
  wire logic [23:0] ans_oe;    // Lanes driven
  wire logic        answering; // Any answer in phase B
  wire logic [23:0] mask_bit;  // Own channel mask lane
  wire logic        drive_now; // Answer goes out at the next edge
  wire iocd_drive_type nxt_drive; // Value and lane enables for the next edge

  assign stat_word = {2'b00, 1'b1, status_count, 16'h0000};
  assign mask_bit  = 24'h000001 << own_channel;
  assign answering = (state_ff == IOCD_WAITB) && (cmd_ff != IOCD_CMD_NONE)
                     && !((cmd_ff == IOCD_CMD_TSRQ) && !service_request);
  assign ans_word  = (cmd_ff == IOCD_CMD_XIN)  ? (stat_word | {8'h00, input_data})
                   : (cmd_ff == IOCD_CMD_TSRQ) ? mask_bit
                   : (cmd_ff == IOCD_CMD_TSTAT || cmd_ff == IOCD_CMD_CLRTST)
                     ? (stat_word | {17'h00000, control_id, 1'b0})
                   : stat_word;
  assign ans_oe    = (cmd_ff == IOCD_CMD_TSRQ) ? mask_bit : 24'hFFFFFF;

  // Stop driving at once on the response strobe or a fresh phase A,
  // so the bus is free before the processor turns it around
  assign drive_now = answering && !response_complete_strobe && !strobe_a;
  // Value and lane enables travel together; all lanes float otherwise
  assign nxt_drive = drive_now ? {ans_word, ans_oe}
                               : {`IOCD_BUS_ZERO, `IOCD_BUS_ZERO};

  // Drive during phase B, release with the response strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_out            <= `IOCD_BUS_ZERO;
      bus_oe             <= `IOCD_BUS_ZERO;
      bus_send_direction <= 1'b0;
      clear_pulse        <= 1'b0;
    end else begin
      clear_pulse        <= strobe_b && (cmd_ff == IOCD_CMD_CLRTST);
      bus_out            <= nxt_drive.dout; // Answer word or all zero
      bus_oe             <= nxt_drive.oe;   // Lanes this control owns
      bus_send_direction <= drive_now;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Lanes come free one edge after the response strobe
  property p_release;
    @(posedge ref_clk) disable iff (!rst_b)
      response_complete_strobe |=> (bus_oe == `IOCD_BUS_ZERO);
  endproperty
  a_release: assert property (p_release) else $error("bus held after response");

  // An idle control never turns the bus around
  property p_idle_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_ff == IOCD_IDLE) |=> !bus_send_direction;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");

  // Transfer-out data is latched from the low lanes at the strobe
  property p_capture;
    @(posedge ref_clk) disable iff (!rst_b)
      (strobe_a && decoded == IOCD_CMD_XOUTA)
        |=> out_data_valid && out_data == $past(bus_in[`IOCD_DATA_HI:0]);
  endproperty
  a_capture: assert property (p_capture) else $error("data not captured");

  // Status words carry the reverse bit and the count of the cycle before
  property p_reverse;
    @(posedge ref_clk) disable iff (!rst_b)
      (bus_send_direction && cmd_ff != IOCD_CMD_TSRQ)
        |-> bus_out[`IOCD_REVERSE_BIT]
            && (bus_out[`IOCD_STAT_HI:`IOCD_STAT_LO] == $past(status_count));
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse bit missing");

  // Clear output is one cycle wide
  sequence s_clear_once;
    clear_pulse ##1 !clear_pulse;
  endsequence

  // Clear follows the phase B strobe of clear-and-test
  property p_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      (strobe_b && cmd_ff == IOCD_CMD_CLRTST) |=> s_clear_once;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not pulsed");

  // Service answer uses exactly one lane
  property p_mask_only;
    @(posedge ref_clk) disable iff (!rst_b)
      (bus_oe != `IOCD_BUS_ZERO && cmd_ff == IOCD_CMD_TSRQ) |-> $onehot(bus_oe);
  endproperty
  a_mask_only: assert property (p_mask_only) else $error("mask drives many lanes");

  // Reserved code leaves nothing to answer
  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_b)
      (strobe_a && basic_code == `IOCD_CODE_XOUTB) |=> cmd_ff == IOCD_CMD_NONE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code accepted");

  // Phase A opens the wait for phase B unless a response strobe ends a wait in the same cycle
  property p_phase;
    @(posedge ref_clk) disable iff (!rst_b)
      strobe_a |=> state_ff == IOCD_WAITB;
  endproperty
  a_phase: assert property (p_phase) else $error("phase A not tracked");

  // ****************************************
  // Checks on the answer drive and contents and the terminate pulse
  // ****************************************
  // A taken command that answers whatever the service request
  sequence s_cmd_taken;
    strobe_a && (decoded != IOCD_CMD_NONE) && (decoded != IOCD_CMD_TSRQ);
  endsequence

  // The edge after phase A carries neither strobe
  sequence s_no_strobe;
    !response_complete_strobe && !command_active_strobe;
  endsequence

  // Answer is on the bus two edges after phase A
  property p_answer_rise;
    @(posedge ref_clk) disable iff (!rst_b)
      s_cmd_taken ##1 s_no_strobe |=> bus_send_direction && (bus_oe != `IOCD_BUS_ZERO);
  endproperty
  a_answer_rise: assert property (p_answer_rise) else $error("answer not driven");

  // Send direction and lane enables always agree
  property p_dir_oe;
    @(posedge ref_clk) disable iff (!rst_b)
      bus_send_direction == (bus_oe != `IOCD_BUS_ZERO);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("direction and lanes disagree");

  // Status tests carry the identity in lanes six to one
  property p_ident;
    @(posedge ref_clk) disable iff (!rst_b)
      (bus_send_direction && (cmd_ff == IOCD_CMD_TSTAT || cmd_ff == IOCD_CMD_CLRTST))
        |-> bus_out[`IOCD_ID_HI:`IOCD_ID_LO] == $past(control_id);
  endproperty
  a_ident: assert property (p_ident) else $error("identity lanes wrong");

  // Transfer in drives the low sixteen lanes with the input word
  property p_xin_data;
    @(posedge ref_clk) disable iff (!rst_b)
      (bus_send_direction && cmd_ff == IOCD_CMD_XIN)
        |-> (bus_out[`IOCD_DATA_HI:0] == $past(input_data)) && (&bus_oe[`IOCD_DATA_HI:0]);
  endproperty
  a_xin_data: assert property (p_xin_data) else $error("input data lanes wrong");

  // Service answer sits on the own channel lane only
  property p_mask_lane;
    @(posedge ref_clk) disable iff (!rst_b)
      (bus_send_direction && cmd_ff == IOCD_CMD_TSRQ)
        |-> bus_oe[$past(own_channel)] && (bus_out == bus_oe);
  endproperty
  a_mask_lane: assert property (p_mask_lane) else $error("mask on wrong lane");

  // Terminate is pulsed for a taken terminate command
  property p_term;
    @(posedge ref_clk) disable iff (!rst_b)
      (strobe_a && decoded == IOCD_CMD_TERM) |=> terminate_pulse;
  endproperty
  a_term: assert property (p_term) else $error("terminate not pulsed");

endmodule // iocd_decoder
`default_nettype wire

// file: iocd_proc_model.sv
// Processor side model: drives strobes and command words, reads answers
`timescale 1ns/1ps
`default_nettype none
module iocd_proc_model (
  input  wire logic        ref_clk,
  input  wire logic [23:0] bus_out,
  input  wire logic [23:0] bus_oe,
  input  wire logic        bus_send_direction,
  output var  logic        command_active_strobe,
  output var  logic        response_complete_strobe,
  output var  logic [23:0] bus_in,
  output var  logic [23:0] rd_word,
  output var  logic [23:0] oe_seen,
  output var  logic        dir_seen
);
  logic [23:0] proc_drv; // Word the processor puts on the bus
  logic        proc_en;  // Processor drives the bus
  logic        seen_clr; // Restart the drive trackers
  initial begin
    command_active_strobe = 1'b0;
    response_complete_strobe = 1'b0;
    proc_drv = 24'h000000;
    proc_en = 1'b0;
    seen_clr = 1'b0;
  end
  // Wire level; free lanes show the processor word in phase A and its inverse otherwise
  always_comb begin
    bus_in = (bus_oe & bus_out) | (~bus_oe & (proc_en ? proc_drv : ~proc_drv));
  end
  // Track any drive by the design within one cycle
  always @(posedge ref_clk) begin
    oe_seen <= seen_clr ? 24'h000000 : (oe_seen | bus_oe);
    dir_seen <= seen_clr ? 1'b0 : (dir_seen | bus_send_direction);
  end
  // One full cycle: phase A word, gap, phase B read
  task automatic run_cycle(input logic [23:0] cmd, input int gap);
    @(negedge ref_clk);
    seen_clr = 1'b1;
    command_active_strobe = 1'b1;
    proc_en = 1'b1;
    proc_drv = cmd;
    @(negedge ref_clk);
    seen_clr = 1'b0;
    command_active_strobe = 1'b0;
    proc_en = 1'b0;
    repeat (gap) @(negedge ref_clk);
    response_complete_strobe = 1'b1;
    @(posedge ref_clk);
    rd_word = bus_in;
    @(negedge ref_clk);
    response_complete_strobe = 1'b0;
    // Five periods from the rise of the response strobe to the next command
    repeat (3) @(negedge ref_clk);
  endtask
endmodule // iocd_proc_model
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the I/O bus command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top import iocd_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_b;
  logic [3:0] own_channel;
  logic [5:0] control_id;
  logic [4:0] status_count;
  logic [15:0] input_data;
  logic service_request;
  wire logic command_active_strobe, response_complete_strobe, bus_send_direction;
  wire logic out_data_valid, clear_pulse, terminate_pulse, dir_seen;
  wire logic [23:0] bus_in, bus_out, bus_oe, rd_word, oe_seen;
  wire logic [15:0] out_data;
  int failures = 0, n_tests = 0, n_odv = 0, n_clr = 0, n_term = 0;
  logic [23:0] corner [9] = '{24'h25BEEF, 24'h45FFFF, 24'h150001, 24'h150003, 24'h1A0005,
                             24'h150006, 24'h35FFFF, 24'h24FFFF, 24'h150002};
  logic [3:0] subs [5] = '{4'h1, 4'h3, 4'h5, 4'h6, 4'h9};
  always #20 ref_clk = ~ref_clk;
  // Count output pulses
  always @(posedge ref_clk) begin
    if (out_data_valid === 1'b1) n_odv++;
    if (clear_pulse === 1'b1) n_clr++;
    if (terminate_pulse === 1'b1) n_term++;
  end
  iocd_decoder DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .command_active_strobe(command_active_strobe),
    .response_complete_strobe(response_complete_strobe), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .bus_send_direction(bus_send_direction),
    .own_channel(own_channel), .control_id(control_id), .status_count(status_count),
    .input_data(input_data), .service_request(service_request), .out_data(out_data),
    .out_data_valid(out_data_valid), .clear_pulse(clear_pulse),
    .terminate_pulse(terminate_pulse));
  iocd_proc_model u_proc (.ref_clk(ref_clk), .bus_out(bus_out), .bus_oe(bus_oe),
    .bus_send_direction(bus_send_direction),
    .command_active_strobe(command_active_strobe),
    .response_complete_strobe(response_complete_strobe), .bus_in(bus_in),
    .rd_word(rd_word), .oe_seen(oe_seen), .dir_seen(dir_seen));
  task automatic check_word(input logic [23:0] got, input logic [23:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask
  // Expected answer mask, value, drive and pulses {valid, clear, term}
  function automatic void expect_of(input logic [23:0] cmd, output logic [23:0] m,
                                    output logic [23:0] v, output logic drv,
                                    output logic [2:0] pul);
    logic hit, sub;
    hit = (cmd[19:16] == own_channel);
    sub = hit && (cmd[23:20] == 4'h1);
    m = 24'h000000;
    pul = {hit && cmd[23:20] == 4'h2, sub && cmd[3:0] == 4'h3, sub && cmd[3:0] == 4'h6};
    v = {3'b001, status_count, (cmd[23:20] == 4'h4) ? input_data : {9'h000, control_id, 1'b0}};
    if (pul[2] || pul[0]) m = 24'h3F0000;
    if (hit && cmd[23:20] == 4'h4) m = 24'h3FFFFF;
    if (sub && (cmd[3:0] == 4'h1 || cmd[3:0] == 4'h3)) m = 24'h3F007E;
    if (cmd[23:20] == 4'h1 && cmd[3:0] == 4'h5 && service_request) begin
      m = 24'h000001 << own_channel;
      v = m;
    end
    drv = (m != 24'h000000);
  endfunction
  // One cycle with all its comparisons
  task automatic run_test(input logic [23:0] cmd, input int gap);
    logic [23:0] m, v;
    logic drv;
    logic [2:0] pul;
    int a, b, c;
    a = n_odv;
    b = n_clr;
    c = n_term;
    expect_of(cmd, m, v, drv, pul);
    u_proc.run_cycle(cmd, gap);
    check_word(rd_word & m, v & m, "answer word");
    check_bit(|oe_seen, drv, "bus drive");
    check_bit(dir_seen, drv, "send direction");
    check_bit(bus_oe === 24'h000000 && bus_send_direction === 1'b0, 1'b1, "release");
    check_bit(n_odv != a, pul[2], "data valid");
    if (pul[2]) check_word({8'h00, out_data}, {8'h00, cmd[15:0]}, "out data");
    check_bit(n_clr != b, pul[1], "clear");
    check_bit(n_term != c, pul[0], "terminate");
    $display("test done cmd %h gap %0d", cmd, gap);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog sized well above the expected run
  initial begin
    #400000;
    failures++;
    report_and_stop;
  end
  // Main sequence: corner table, then random cycles
  initial begin
    logic [23:0] cmd;
    rst_b = 1'b0;
    own_channel = 4'h5;
    control_id = 6'h2A;
    status_count = 5'h1F;
    input_data = 16'hA5C3;
    service_request = 1'b1;
    void'($urandom(32'h6c4aaf01));
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    check_word(bus_oe, 24'h000000, "reset drive");
    foreach (corner[i]) run_test(corner[i], 1);
    repeat (200) begin
      own_channel = $urandom;
      control_id = $urandom;
      status_count = $urandom;
      input_data = $urandom;
      service_request = $urandom;
      cmd = $urandom;
      cmd[23:20] = $urandom_range(0, 5);
      if ($urandom % 2) cmd[19:16] = own_channel;
      if ($urandom % 4 != 0) cmd[3:0] = subs[$urandom % 5];
      run_test(cmd, $urandom_range(1, 4));
    end
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
